//--- hw/psi_pkg.sv
// constants, field layouts and carrier types for the partition security and irq block
package psi_pkg;

    // ****************************************
    // register offsets (byte addresses in the 64 KB page)
    // ****************************************
    localparam logic [15:0] OFS_PART_SEL = 16'h0000;
    localparam logic [15:0] OFS_MON_SEL = 16'h0004;
    localparam logic [15:0] OFS_PART_CFG = 16'h0008;
    localparam logic [15:0] OFS_MON_CTL = 16'h000C;
    localparam logic [15:0] OFS_MON_CNT = 16'h0010;
    localparam logic [15:0] OFS_ERR_STATUS = 16'h0014;
    localparam logic [15:0] OFS_ERR_CTL = 16'h0018;
    localparam logic [15:0] OFS_SEC_CFG = 16'h001C;

    // ****************************************
    // sizes
    // ****************************************
    localparam int PID_W = 8;
    localparam int PMG_W = 8;
    localparam int RIS_W = 4;
    localparam int CFG_W = 16;
    localparam int CNT_W = 32;
    localparam int NMON = 2;
    localparam logic [PID_W-1:0] S_PARTS = 8'h04;
    localparam logic [PID_W-1:0] NS_PARTS = 8'h06;
    localparam logic [RIS_W-1:0] RIS_MAX = 4'h0;

    // ****************************************
    // error codes
    // ****************************************
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_SEC_ONLY = 4'h1;
    localparam logic [3:0] ERR_PID_RANGE = 4'h2;
    localparam logic [3:0] ERR_PART_RIS = 4'h8;
    localparam logic [3:0] ERR_MON_RIS = 4'hA;
    localparam logic [3:0] ERR_MON_RANGE = 4'hC;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int ECR_EN_BIT = 0;
    localparam int SEC_MON_EN_BIT = 0;
    localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic SEC_MON_EN_RST = 1'b1;

    typedef struct packed {
        logic security_tag;
        logic [PID_W-1:0] partition_id;
        logic [PMG_W-1:0] monitor_group;
    } psi_req_t;

    typedef struct packed {
        logic [RIS_W-1:0] resource_instance;
        logic [PID_W-1:0] partition_id;
    } psi_part_sel_t;

    typedef struct packed {
        logic [RIS_W-1:0] resource_instance;
        logic [7:0] monitor;
    } psi_mon_sel_t;

    typedef struct packed {
        logic overflow_flag;
        logic overflow_irq_enable;
        logic enable;
        logic [PMG_W-1:0] monitor_group;
        logic [PID_W-1:0] partition_id;
    } psi_mon_ctl_t;

    typedef struct packed {
        logic [RIS_W-1:0] resource_instance;
        logic [3:0] error_code;
    } psi_esr_t;

endpackage

//--- hw/psi_top.sv
// banked partition tables, monitors and error/overflow interrupts
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// Functional notes
// - one register is reachable only by accesses with ns equal to 0
// - tag 0 requests use secure table, tag 1 requests use non-secure table
// - secure settings stored only by ns 0 accesses, non-secure by ns 1
// - partition_select and monitor_select banked at one address by ns
// - config access acts on the partition chosen by its own bank's selector
// - separate secure and non-secure tables, unequal sizes, 4 and 6 entries
// - monitor counts only when partition_id, monitor_group and tag all match
// - errors recorded in error_status_reg; irq only when error_irq_enable is 1
// - without any error source both error registers read zero, ignore writes
// - error registers banked; each copy drives only its own space's irq
// - error irq level or edge; level default, one output per space
// - level irq holds while error_code non-zero; software clears with zero
// - edge irq pulses on hardware error writes only, never software writes
// - counter overflow with overflow_irq_enable 1 raises overflow irq
// - monitor controls and counters banked; enable governs own space only
// - overflow irq level, held while any overflow_flag is set with its overflow_irq_enable 1
// - separate secure and non-secure overflow irq outputs
// - register page decoded as one 64 KB aligned page
// - errors report selector resource_instance, or 0 when none captured
module psi_top #(
    parameter bit ERR_EDGE_MODE = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_ns_i,
    output logic [31:0] reg_rdata_o,
    input wire logic req_valid_i,
    input wire psi_pkg::psi_req_t req_i,
    output logic req_cfg_valid_o,
    output logic [psi_pkg::CFG_W-1:0] req_cfg_o,
    output logic err_irq_s_o,
    output logic err_irq_ns_o,
    output logic of_irq_s_o,
    output logic of_irq_ns_o
);
    import psi_pkg::*;

    // ****************************************
    // state
    // ****************************************
    psi_part_sel_t part_sel [2];
    psi_mon_sel_t mon_sel [2];
    logic [CFG_W-1:0] s_tbl [4];
    logic [CFG_W-1:0] ns_tbl [6];
    psi_mon_ctl_t mon_ctl [2][NMON];
    logic [CNT_W-1:0] mon_cnt [2][NMON];
    psi_esr_t esr [2];
    logic ecr_en [2];
    logic sec_mon_en;
    logic [1:0] err_irq;
    logic [1:0] of_irq;

    // ****************************************
    // address decode
    // ****************************************
    wire sp = reg_ns_i; // bank index, 0 secure, 1 non-secure
    wire acc = reg_wr_i | reg_rd_i;
    // full 16-bit offset decode, the page holds nothing else
    wire hit_psel = (reg_addr_i == OFS_PART_SEL);
    wire hit_msel = (reg_addr_i == OFS_MON_SEL);
    wire hit_pcfg = (reg_addr_i == OFS_PART_CFG);
    wire hit_mctl = (reg_addr_i == OFS_MON_CTL);
    wire hit_mcnt = (reg_addr_i == OFS_MON_CNT);
    wire hit_esr = (reg_addr_i == OFS_ERR_STATUS);
    wire hit_ecr = (reg_addr_i == OFS_ERR_CTL);
    wire hit_sec = (reg_addr_i == OFS_SEC_CFG);

    // ****************************************
    // selectors of the accessing bank
    // ****************************************
    wire [PID_W-1:0] sel_pid = part_sel[sp].partition_id;
    wire [RIS_W-1:0] sel_pris = part_sel[sp].resource_instance;
    wire [7:0] sel_mon = mon_sel[sp].monitor;
    wire [RIS_W-1:0] sel_mris = mon_sel[sp].resource_instance;
    wire mi = sel_mon[0];
    wire pid_ok = sp ? (sel_pid < NS_PARTS) : (sel_pid < S_PARTS);
    wire pris_ok = (sel_pris <= RIS_MAX);
    wire mris_ok = (sel_mris <= RIS_MAX);
    wire mon_ok = (sel_mon < 8'(NMON));
    wire hit_mon = hit_mctl | hit_mcnt;

    // ****************************************
    // error detection
    // ****************************************
    wire err_sec = acc & hit_sec & reg_ns_i;
    wire err_pris = acc & hit_pcfg & ~pris_ok;
    wire err_pid = acc & hit_pcfg & pris_ok & ~pid_ok;
    wire err_mris = acc & hit_mon & ~mris_ok;
    wire err_mrng = acc & hit_mon & mris_ok & ~mon_ok;
    wire hw_err = err_sec | err_pris | err_pid | err_mris | err_mrng;
    wire [3:0] hw_code = err_sec ? ERR_SEC_ONLY :
                         err_pris ? ERR_PART_RIS :
                         err_pid ? ERR_PID_RANGE :
                         err_mris ? ERR_MON_RIS : ERR_MON_RANGE;
    // instance from the selector involved, zero for the secure-only fault
    wire [RIS_W-1:0] hw_ris = (err_pris | err_pid) ? sel_pris :
                              (err_mris | err_mrng) ? sel_mris :
                              {RIS_W{1'b0}};
    // hardware capture outranks a same-cycle software status write
    wire [7:0] next_esr = hw_err ? {hw_ris, hw_code} :
                                   {reg_wdata_i[11:8], reg_wdata_i[3:0]};

    // ****************************************
    // accepted writes
    // ****************************************
    wire we_psel = reg_wr_i & hit_psel;
    wire we_msel = reg_wr_i & hit_msel;
    wire we_pcfg = reg_wr_i & hit_pcfg & pris_ok & pid_ok;
    wire we_mctl = reg_wr_i & hit_mctl & mris_ok & mon_ok;
    wire we_mcnt = reg_wr_i & hit_mcnt & mris_ok & mon_ok;
    wire we_esr = reg_wr_i & hit_esr;
    wire we_ecr = reg_wr_i & hit_ecr;
    wire we_sec = reg_wr_i & hit_sec & ~reg_ns_i;

    // ****************************************
    // read mux
    // ****************************************
    wire [CFG_W-1:0] cfg_rd = sp ? ns_tbl[sel_pid[2:0]] : s_tbl[sel_pid[1:0]];
    wire [31:0] rd_psel = {20'h0_0000, part_sel[sp]};
    wire [31:0] rd_msel = {20'h0_0000, mon_sel[sp]};
    wire [31:0] rd_pcfg = (pris_ok & pid_ok) ? {16'h0000, cfg_rd} : 32'h0000_0000;
    wire [31:0] rd_mctl = (mris_ok & mon_ok) ? {13'h0000, mon_ctl[sp][mi]} : 32'h0000_0000;
    wire [31:0] rd_mcnt = (mris_ok & mon_ok) ? mon_cnt[sp][mi] : 32'h0000_0000;
    wire [31:0] rd_esr = {20'h0_0000, esr[sp].resource_instance, 4'h0, esr[sp].error_code};
    // error sources exist, so both error registers are real, not read-as-zero
    wire [31:0] rd_ecr = {31'h0000_0000, ecr_en[sp]};
    wire [31:0] rd_sec = reg_ns_i ? 32'h0000_0000 : {31'h0000_0000, sec_mon_en};
    wire [31:0] rd_mux = hit_psel ? rd_psel :
                         hit_msel ? rd_msel :
                         hit_pcfg ? rd_pcfg :
                         hit_mctl ? rd_mctl :
                         hit_mcnt ? rd_mcnt :
                         hit_esr ? rd_esr :
                         hit_ecr ? rd_ecr :
                         hit_sec ? rd_sec : 32'h0000_0000;

    // ****************************************
    // request path lookup
    // ****************************************
    wire req_pid_ok = req_i.security_tag ? (req_i.partition_id < NS_PARTS) :
                                          (req_i.partition_id < S_PARTS);
    // out-of-range ids have no defined settings; zero is the safe answer
    wire [CFG_W-1:0] req_lookup = ~req_pid_ok ? CFG_RST :
                                  req_i.security_tag ? ns_tbl[req_i.partition_id[2:0]] :
                                                       s_tbl[req_i.partition_id[1:0]];

    // ****************************************
    // monitor match and overflow
    // ****************************************
    logic inc [2][NMON];
    logic ovf [2][NMON];
    logic wr_cnt [2][NMON];
    logic wr_ctl [2][NMON];
    logic [CNT_W-1:0] next_cnt [2][NMON];
    wire [NMON-1:0] flag_on [2];
    wire [1:0] of_any;

    genvar gs, gm;
    generate
        for (gs = 0; gs < 2; gs++) begin : g_sp
            for (gm = 0; gm < NMON; gm++) begin : g_mon
                // secure monitors may be frozen from the secure-only register
                assign inc[gs][gm] = req_valid_i & mon_ctl[gs][gm].enable
                    & (req_i.security_tag == 1'(gs))
                    & (req_i.partition_id == mon_ctl[gs][gm].partition_id)
                    & (req_i.monitor_group == mon_ctl[gs][gm].monitor_group)
                    & ((gs != 0) | sec_mon_en);
                assign wr_cnt[gs][gm] = we_mcnt & (sp == 1'(gs)) & (mi == 1'(gm));
                assign wr_ctl[gs][gm] = we_mctl & (sp == 1'(gs)) & (mi == 1'(gm));
                assign ovf[gs][gm] = inc[gs][gm] & (&mon_cnt[gs][gm]) & ~wr_cnt[gs][gm];
                // a software counter write beats a same-cycle increment
                assign next_cnt[gs][gm] = wr_cnt[gs][gm] ? reg_wdata_i :
                                          mon_cnt[gs][gm] + 32'h0000_0001;
                assign flag_on[gs][gm] = mon_ctl[gs][gm].overflow_flag
                    & mon_ctl[gs][gm].overflow_irq_enable;
            end

            // any flagged monitor with its enable keeps the line up
            assign of_any[gs] = |flag_on[gs];
        end
    endgenerate

    // ****************************************
    // read data
    // ****************************************
    // idle cycles read zero so a stale word never looks like an answer
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    // ****************************************
    // secure-only monitor enable
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_mon_en <= SEC_MON_EN_RST;
        end else if (we_sec) begin
            sec_mon_en <= reg_wdata_i[SEC_MON_EN_BIT];
        end
    end

    // ****************************************
    // bank selectors
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int s = 0; s < 2; s++) begin
                part_sel[s] <= '0;
                mon_sel[s] <= '0;
            end
        end else begin
            if (we_psel) begin
                part_sel[sp] <= reg_wdata_i[11:0];
            end
            if (we_msel) begin
                mon_sel[sp] <= reg_wdata_i[11:0];
            end
        end
    end

    // ****************************************
    // partition tables
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                s_tbl[i] <= CFG_RST;
            end
            for (int i = 0; i < 6; i++) begin
                ns_tbl[i] <= CFG_RST;
            end
        end else if (we_pcfg) begin
            if (sp) begin
                ns_tbl[sel_pid[2:0]] <= reg_wdata_i[CFG_W-1:0];
            end else begin
                s_tbl[sel_pid[1:0]] <= reg_wdata_i[CFG_W-1:0];
            end
        end
    end

    // ****************************************
    // request output
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_cfg_valid_o <= 1'b0;
            req_cfg_o <= CFG_RST;
        end else begin
            req_cfg_valid_o <= req_valid_i;
            req_cfg_o <= req_valid_i ? req_lookup : CFG_RST;
        end
    end

    // ****************************************
    // monitors
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int s = 0; s < 2; s++) begin
                for (int m = 0; m < NMON; m++) begin
                    mon_ctl[s][m] <= '0;
                    mon_cnt[s][m] <= CNT_RST;
                end
            end
        end else begin
            for (int s = 0; s < 2; s++) begin
                for (int m = 0; m < NMON; m++) begin
                    if (wr_cnt[s][m] | inc[s][m]) begin
                        mon_cnt[s][m] <= next_cnt[s][m];
                    end
                    if (wr_ctl[s][m]) begin
                        mon_ctl[s][m] <= reg_wdata_i[18:0];
                    end
                    // set wins over a software clear in the same cycle
                    if (ovf[s][m]) begin
                        mon_ctl[s][m].overflow_flag <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************
    // error status and control, one copy per space
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int s = 0; s < 2; s++) begin
                esr[s] <= '0;
                ecr_en[s] <= 1'b0;
            end
        end else begin
            if (hw_err | we_esr) begin
                esr[sp] <= next_esr;
            end
            if (we_ecr) begin
                ecr_en[sp] <= reg_wdata_i[ECR_EN_BIT];
            end
        end
    end

    // ****************************************
    // interrupt next values
    // ****************************************
    // edge form fires on hardware errors only
    wire [1:0] err_level = {ecr_en[1] & (|esr[1].error_code),
                            ecr_en[0] & (|esr[0].error_code)};
    wire [1:0] err_pulse = {ecr_en[1] & hw_err & sp, ecr_en[0] & hw_err & ~sp};
    wire [1:0] next_err_irq = ERR_EDGE_MODE ? err_pulse : err_level;

    // ****************************************
    // interrupt outputs
    // ****************************************
    // level form costs one cycle of latency so the pin comes from a flop
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_irq <= 2'b00;
            of_irq <= 2'b00;
        end else begin
            err_irq <= next_err_irq;
            of_irq <= of_any;
        end
    end

    assign err_irq_s_o = err_irq[0];
    assign err_irq_ns_o = err_irq[1];
    assign of_irq_s_o = of_irq[0];
    assign of_irq_ns_o = of_irq[1];

endmodule // psi_top

//--- verif/psi_requester.sv
// requester model sending partition-tagged requests
`timescale 1ns/10ps
module psi_requester (
    input wire logic core_clk_i,
    output logic req_valid_o,
    output psi_pkg::psi_req_t req_o
);
    import psi_pkg::*;
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    task automatic send(input logic sec, input logic [PID_W-1:0] pid, input logic [PMG_W-1:0] g);
        @(posedge core_clk_i);
        req_valid_o <= 1'b1;
        req_o.security_tag <= ~sec;
        req_o.partition_id <= pid;
        req_o.monitor_group <= g;
        @(posedge core_clk_i);
        req_valid_o <= 1'b0;
        // released bus must not keep looking like the last request
        req_o <= ~req_o;
    endtask
endmodule // psi_requester

//--- verif/psi_top_monitor.sv
// port checker for psi_top, bound to every instance
`timescale 1ns/10ps
module psi_top_monitor (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_ns_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic req_valid_i,
    input wire psi_pkg::psi_req_t req_i,
    input wire logic req_cfg_valid_o,
    input wire logic [psi_pkg::CFG_W-1:0] req_cfg_o,
    input wire logic err_irq_s_o,
    input wire logic err_irq_ns_o,
    input wire logic of_irq_s_o,
    input wire logic of_irq_ns_o
);
    import psi_pkg::*;
    // ****************************************
    // bank-qualified strobes
    // ****************************************
    wire logic s_acc = (reg_wr_i | reg_rd_i) & ~reg_ns_i;
    wire logic n_acc = (reg_wr_i | reg_rd_i) & reg_ns_i;
    wire logic s_wr = reg_wr_i & ~reg_ns_i;
    wire logic n_wr = reg_wr_i & reg_ns_i;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_cfg_valid;
        req_cfg_valid_o == $past(req_valid_i);
    endproperty
    a_cfg_valid: assert property (p_cfg_valid) else $error("cfg valid misplaced");
    property p_s_range;
        req_valid_i && !req_i.security_tag && req_i.partition_id >= S_PARTS |=> req_cfg_o == '0;
    endproperty
    a_s_range: assert property (p_s_range) else $error("secure id out of range");
    property p_ns_range;
        req_valid_i && req_i.security_tag && req_i.partition_id >= NS_PARTS |=> req_cfg_o == '0;
    endproperty
    a_ns_range: assert property (p_ns_range) else $error("ns id out of range");
    property p_sec_only;
        reg_rd_i && reg_ns_i && reg_addr_i == OFS_SEC_CFG |=> reg_rdata_o == 32'h0000_0000;
    endproperty
    a_sec_only: assert property (p_sec_only) else $error("ns read of secure page");
    property p_err_rise_s;
        $rose(err_irq_s_o) |-> $past(s_acc, 2);
    endproperty
    a_err_rise_s: assert property (p_err_rise_s) else $error("secure err irq uncaused");
    property p_err_rise_ns;
        $rose(err_irq_ns_o) |-> $past(n_acc, 2);
    endproperty
    a_err_rise_ns: assert property (p_err_rise_ns) else $error("ns err irq uncaused");
    property p_err_fall_s;
        $fell(err_irq_s_o) |-> $past(s_wr, 2);
    endproperty
    a_err_fall_s: assert property (p_err_fall_s) else $error("secure err irq dropped");
    property p_of_rise_s;
        $rose(of_irq_s_o) |-> $past((req_valid_i && !req_i.security_tag) || s_wr, 2);
    endproperty
    a_of_rise_s: assert property (p_of_rise_s) else $error("secure ovf irq uncaused");
    property p_of_rise_ns;
        $rose(of_irq_ns_o) |-> $past((req_valid_i && req_i.security_tag) || n_wr, 2);
    endproperty
    a_of_rise_ns: assert property (p_of_rise_ns) else $error("ns ovf irq uncaused");
    property p_of_fall_ns;
        $fell(of_irq_ns_o) |-> $past(n_wr, 2);
    endproperty
    a_of_fall_ns: assert property (p_of_fall_ns) else $error("ns ovf irq dropped");
endmodule // psi_top_monitor

bind psi_top psi_top_monitor u_mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_ns_i(reg_ns_i), .reg_rdata_o(reg_rdata_o),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_cfg_valid_o(req_cfg_valid_o),
    .req_cfg_o(req_cfg_o), .err_irq_s_o(err_irq_s_o), .err_irq_ns_o(err_irq_ns_o),
    .of_irq_s_o(of_irq_s_o), .of_irq_ns_o(of_irq_ns_o));

//--- verif/psi_top_tb_top.sv
// self-checking bench for psi_top
`timescale 1ns/10ps
module psi_top_tb_top;
    import psi_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic reg_ns_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic req_valid_i;
    psi_req_t req_i;
    logic req_cfg_valid_o;
    logic [CFG_W-1:0] req_cfg_o;
    logic err_irq_s_o, err_irq_ns_o, of_irq_s_o, of_irq_ns_o;
    int fail_count = 0;
    int n_compared = 0;
    logic [15:0] rnd = 16'hC65F;
    logic [CFG_W-1:0] s_tab [4] = '{default: CFG_RST};
    logic [CFG_W-1:0] ns_tab [6] = '{default: CFG_RST};
    logic [7:0] sid, nid, grp;
    logic [31:0] ctl;
    logic bk;

    psi_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_ns_i(reg_ns_i), .reg_rdata_o(reg_rdata_o), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_cfg_valid_o(req_cfg_valid_o), .req_cfg_o(req_cfg_o),
        .err_irq_s_o(err_irq_s_o), .err_irq_ns_o(err_irq_ns_o), .of_irq_s_o(of_irq_s_o),
        .of_irq_ns_o(of_irq_ns_o));
    psi_requester u_req (.core_clk_i(core_clk_i), .req_valid_o(req_valid_i), .req_o(req_i));

    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [CFG_W-1:0] exp_cfg(input logic tag, input logic [7:0] id);
        if (tag)
            return (id < NS_PARTS) ? ns_tab[id] : CFG_RST;
        return (id < S_PARTS) ? s_tab[id] : CFG_RST;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic ns, input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_ns_i <= ns;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic ns, input logic [15:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_ns_i <= ns;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(reg_rdata_o, exp);
    endtask
    // irq order: secure err, ns err, secure ovf, ns ovf
    task automatic irq(input logic [3:0] exp);
        repeat (2) @(posedge core_clk_i);
        #1;
        check({28'h0, err_irq_s_o, err_irq_ns_o, of_irq_s_o, of_irq_ns_o}, {28'h0, exp});
    endtask
    task automatic req(input logic sec, input logic [7:0] id, input logic [7:0] g,
        input logic [CFG_W-1:0] exp);
        u_req.send(sec, id, g);
        #1;
        check({16'h0, req_cfg_o}, {16'h0, exp});
        check({31'h0, req_cfg_valid_o}, 32'h0000_0001);
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        wrap_up();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(1'b0, OFS_SEC_CFG, 32'h0000_0001);
        rd(1'b1, OFS_SEC_CFG, 32'h0000_0000);
        rd(1'b1, OFS_ERR_STATUS, 32'h0000_0001);
        irq(4'b0000);
        wr(1'b1, OFS_ERR_STATUS, 32'h0000_0000);
        rd(1'b0, OFS_ERR_STATUS, 32'h0000_0000);
        wr(1'b0, 16'h0040, 32'h0000_5A5A);
        rd(1'b0, 16'h0040, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            sid = {6'h00, rnd[1:0]};
            nid = (rnd[4:2] > 3'd5) ? 8'h05 : {5'h00, rnd[4:2]};
            wr(1'b0, OFS_PART_SEL, {24'h0, sid});
            wr(1'b1, OFS_PART_SEL, {24'h0, nid});
            s_tab[sid] = rnd;
            wr(1'b0, OFS_PART_CFG, {16'h0, rnd});
            rnd = lfsr(rnd);
            ns_tab[nid] = rnd;
            wr(1'b1, OFS_PART_CFG, {16'h0, rnd});
            rd(1'b0, OFS_PART_SEL, {24'h0, sid});
            rd(1'b0, OFS_PART_CFG, {16'h0, s_tab[sid]});
            rd(1'b1, OFS_PART_SEL, {24'h0, nid});
            rd(1'b1, OFS_PART_CFG, {16'h0, ns_tab[nid]});
        end
        for (int k = 0; k < 24; k++) begin
            rnd = lfsr(rnd);
            nid = {5'h00, rnd[6:4]};
            req(rnd[3], nid, rnd[15:8], exp_cfg(~rnd[3], nid));
        end
        req(1'b1, 8'h04, 8'h00, CFG_RST);
        req(1'b0, 8'h06, 8'h00, CFG_RST);
        req(1'b0, 8'h05, 8'h00, ns_tab[5]);
        for (int b = 0; b < 2; b++) begin
            bk = b[0];
            wr(bk, OFS_ERR_CTL, 32'h0000_0001);
            wr(bk, OFS_PART_SEL, 32'h0000_0300);
            rd(bk, OFS_PART_CFG, 32'h0000_0000);
            irq(bk ? 4'b0100 : 4'b1000);
            rd(bk, OFS_ERR_STATUS, 32'h0000_0308);
            wr(bk, OFS_PART_SEL, 32'h0000_0007);
            wr(bk, OFS_ERR_STATUS, 32'h0000_0000);
            irq(4'b0000);
            rd(bk, OFS_PART_CFG, 32'h0000_0000);
            rd(bk, OFS_ERR_STATUS, 32'h0000_0002);
            wr(bk, OFS_ERR_STATUS, 32'h0000_0005);
            irq(bk ? 4'b0100 : 4'b1000);
            wr(bk, OFS_ERR_CTL, 32'h0000_0000);
            irq(4'b0000);
            wr(bk, OFS_ERR_STATUS, 32'h0000_0000);
            wr(bk, OFS_PART_SEL, 32'h0000_0000);
        end
        for (int b = 0; b < 2; b++) begin
            bk = b[0];
            rnd = lfsr(rnd);
            sid = {6'h00, rnd[1:0]};
            grp = rnd[15:8];
            ctl = {13'h0, 3'b011, grp, sid};
            wr(bk, OFS_MON_SEL, 32'h0000_0000);
            wr(bk, OFS_MON_CNT, 32'hFFFF_FFFE);
            wr(bk, OFS_MON_CTL, ctl);
            req(~bk, sid, grp ^ 8'h01, exp_cfg(bk, sid));
            req(bk, sid, grp, exp_cfg(~bk, sid));
            rd(bk, OFS_MON_CNT, 32'hFFFF_FFFE);
            wr(1'b0, OFS_SEC_CFG, 32'h0000_0000);
            req(1'b1, sid, grp, exp_cfg(1'b0, sid));
            rd(bk, OFS_MON_CNT, 32'hFFFF_FFFE);
            wr(1'b0, OFS_SEC_CFG, 32'h0000_0001);
            req(~bk, sid, grp, exp_cfg(bk, sid));
            rd(bk, OFS_MON_CNT, 32'hFFFF_FFFF);
            req(~bk, sid, grp, exp_cfg(bk, sid));
            irq(bk ? 4'b0001 : 4'b0010);
            rd(bk, OFS_MON_CNT, 32'h0000_0000);
            rd(bk, OFS_MON_CTL, ctl | 32'h0004_0000);
            wr(bk, OFS_MON_CTL, ctl);
            irq(4'b0000);
        end
        wrap_up();
    end
endmodule // psi_top_tb_top
